/* File: fpb_pkg.sv */
package fpb_pkg;
   localparam logic [7:0] ADDR_MAX_LO   = 8'h19;
   localparam logic [7:0] ADDR_MAX_HI   = 8'h1a;
   localparam logic [7:0] ADDR_MIN_LO   = 8'h1b;
   localparam logic [7:0] ADDR_MIN_HI   = 8'h1c;
   localparam logic [7:0] ADDR_EXP_LO   = 8'h1d;
   localparam logic [7:0] ADDR_EXP_HI   = 8'h1e;
   localparam logic [7:0] ADDR_EXT_CFG  = 8'h20;
   localparam logic [7:0] RST_MAX_LO    = 8'h90;
   localparam logic [7:0] RST_MAX_HI    = 8'h65;
   localparam logic [7:0] RST_MIN_LO    = 8'h7e;
   localparam logic [7:0] RST_MIN_HI    = 8'h0e;
   localparam logic [7:0] RST_EXP_LO    = 8'h20;
   localparam logic [7:0] RST_EXP_HI    = 8'h4e;
   localparam int         EXT_AUTO_BIT  = 0;
   localparam int         EXT_BUSY_BIT  = 7;
   localparam logic [7:0] RST_EXT_CFG   = 8'h01;
   localparam logic [15:0] MIN_PERIOD_FLOOR = 16'h0d3e;
   localparam logic [1:0] SETTLE_FRAMES = 2'h2;
   // host command port
   localparam logic [1:0] HOST_ADDR_CTRL = 2'h0;
   localparam logic [1:0] HOST_ADDR_STAT = 2'h1;
   localparam logic [1:0] HOST_ADDR_RDAT = 2'h2;
   localparam logic [1:0] HOST_ADDR_WDAT = 2'h3;
endpackage

/* File: fpb_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fpb_if;
   logic       wr;
   logic       rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev  (input wr, input rd, input addr, input wdata, output rdata);
   modport host (output wr, output rd, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

/* File: fpb_dev.sv */
// Functional notes
// (RULE1) max period caps auto, sets manual
// (RULE2) min period floors automatic rate choice
// (RULE3) controller reads upper byte first
// (RULE4) controller writes lower byte first
// (RULE5) max upper write activates all pending
// (RULE6) writes stay pending until activation
// (RULE7) activation takes two full frames
// (RULE8) no bound writes during activation; neither host nor device blocks them, software must poll busy
// (RULE9) busy bit shows activation in progress
// (RULE10) max at least min plus shutter; not checked by host or device, left to software
// (RULE11) min period written within 0d3e..ffff
// (RULE12) min period reads back pending value
// (RULE13) manual rate: auto off, write max
// (RULE14) frame rate equals clock over count
// (RULE15) shutter bound caps automatic exposure
// (RULE16) busy set at activation, cleared after
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fpb_dev (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   fpb_if.dev               bus,
   input  wire logic [15:0] req_period,
   input  wire logic [15:0] req_exposure,
   output logic      [15:0] frame_period,
   output logic      [15:0] exposure_limit,
   output logic             frame_tick,
   output logic             busy,
   output logic             auto_mode
);
   logic [7:0]  pend_ff [6];
   logic [7:0]  nxt_pend [6];
   logic [15:0] act_max_ff, act_min_ff, act_exp_ff;
   logic [15:0] nxt_act_max, nxt_act_min, nxt_act_exp;
   logic [7:0]  ext_ff, nxt_ext;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [1:0]  settle_ff, nxt_settle;
   logic        tick_ff, nxt_tick;
   logic [15:0] period_ff, nxt_period, exp_ff, nxt_exp;
   logic [15:0] clip;
   logic        wrap;

   assign bus.rdata      = rdata_ff;
   assign frame_period   = period_ff;
   assign exposure_limit = exp_ff;
   assign frame_tick     = tick_ff;
   assign busy           = ext_ff[fpb_pkg::EXT_BUSY_BIT];
   assign auto_mode      = ext_ff[fpb_pkg::EXT_AUTO_BIT];

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         nxt_pend[i] = pend_ff[i];
      end
      nxt_ext     = ext_ff;
      nxt_rdata   = 8'h00;
      nxt_act_max = act_max_ff;
      nxt_act_min = act_min_ff;
      nxt_act_exp = act_exp_ff;
      nxt_settle  = settle_ff;
      wrap        = (cnt_ff + 16'h0001 >= period_ff);
      nxt_cnt     = wrap ? 16'h0000 : cnt_ff + 16'h0001;
      nxt_tick    = wrap;
      // frame counter period = bound count, rate = clk / count [RULE14]
      if (wrap && settle_ff != 2'h0) begin
         nxt_settle = settle_ff - 2'h1; // two frame settle [RULE7]
      end
      if (bus.wr) begin
         if (bus.addr >= fpb_pkg::ADDR_MAX_LO && bus.addr <= fpb_pkg::ADDR_EXP_HI) begin
            nxt_pend[3'(bus.addr - fpb_pkg::ADDR_MAX_LO)] = bus.wdata; // held pending [RULE6]
         end
         if (bus.addr == fpb_pkg::ADDR_EXT_CFG) begin
            nxt_ext[fpb_pkg::EXT_AUTO_BIT] = bus.wdata[fpb_pkg::EXT_AUTO_BIT];
         end
         if (bus.addr == fpb_pkg::ADDR_MAX_HI) begin
            // upper byte completes the pair: activate all [RULE5]
            nxt_act_max = {bus.wdata, pend_ff[0]};
            nxt_act_min = {pend_ff[3], pend_ff[2]};
            nxt_act_exp = {pend_ff[5], pend_ff[4]};
            nxt_settle  = fpb_pkg::SETTLE_FRAMES; // [RULE16]
         end
      end
      nxt_ext[fpb_pkg::EXT_BUSY_BIT] = (nxt_settle != 2'h0); // [RULE9] [RULE16]
      if (bus.rd) begin
         if (bus.addr >= fpb_pkg::ADDR_MAX_LO && bus.addr <= fpb_pkg::ADDR_EXP_HI) begin
            nxt_rdata = pend_ff[3'(bus.addr - fpb_pkg::ADDR_MAX_LO)]; // latest written [RULE12]
         end else if (bus.addr == fpb_pkg::ADDR_EXT_CFG) begin
            nxt_rdata = ext_ff;
         end
      end
   end

   always_comb begin
      // auto: clamp request into [min, max]; manual: max is the period [RULE1] [RULE2] [RULE13]
      clip = req_period;
      if (clip < act_min_ff) begin
         clip = act_min_ff;
      end
      if (clip > act_max_ff) begin
         clip = act_max_ff;
      end
      nxt_period = period_ff;
      nxt_exp    = exp_ff;
      if (wrap && settle_ff == 2'h1) begin
         nxt_exp = act_exp_ff; // apply once settled [RULE7]
      end
      if (wrap && settle_ff == 2'h0) begin
         nxt_period = ext_ff[fpb_pkg::EXT_AUTO_BIT] ? clip : act_max_ff;
         nxt_exp    = (req_exposure > act_exp_ff) ? act_exp_ff : req_exposure; // [RULE15]
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_ff[0] <= fpb_pkg::RST_MAX_LO;
         pend_ff[1] <= fpb_pkg::RST_MAX_HI;
         pend_ff[2] <= fpb_pkg::RST_MIN_LO;
         pend_ff[3] <= fpb_pkg::RST_MIN_HI;
         pend_ff[4] <= fpb_pkg::RST_EXP_LO;
         pend_ff[5] <= fpb_pkg::RST_EXP_HI;
         act_max_ff <= {fpb_pkg::RST_MAX_HI, fpb_pkg::RST_MAX_LO};
         act_min_ff <= {fpb_pkg::RST_MIN_HI, fpb_pkg::RST_MIN_LO};
         act_exp_ff <= {fpb_pkg::RST_EXP_HI, fpb_pkg::RST_EXP_LO};
         period_ff  <= {fpb_pkg::RST_MAX_HI, fpb_pkg::RST_MAX_LO};
         exp_ff     <= {fpb_pkg::RST_EXP_HI, fpb_pkg::RST_EXP_LO};
         ext_ff     <= fpb_pkg::RST_EXT_CFG;
         rdata_ff   <= 8'h00;
         cnt_ff     <= 16'h0000;
         settle_ff  <= 2'h0;
         tick_ff    <= 1'b0;
      end else if (clk_en) begin
         for (int i = 0; i < 6; i++) begin
            pend_ff[i] <= nxt_pend[i];
         end
         act_max_ff <= nxt_act_max;
         act_min_ff <= nxt_act_min;
         act_exp_ff <= nxt_act_exp;
         period_ff  <= nxt_period;
         exp_ff     <= nxt_exp;
         ext_ff     <= nxt_ext;
         rdata_ff   <= nxt_rdata;
         cnt_ff     <= nxt_cnt;
         settle_ff  <= nxt_settle;
         tick_ff    <= nxt_tick;
      end
   end
endmodule
`default_nettype wire

/* File: fpb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fpb_host (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   fpb_if.host              bus,
   input  wire logic [1:0]  sw_addr,
   input  wire logic [15:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [15:0] sw_rdata
);
   typedef enum logic [2:0] {S_IDLE, S_WLO, S_WHI, S_RHI, S_RLO, S_RDONE, S_RFIN} fpb_hst_t;
   fpb_hst_t    st_ff, nxt_st;
   logic [7:0]  base_ff, nxt_base;
   logic [15:0] wd_ff, nxt_wd, rd_ff, nxt_rd, rdo_ff, nxt_rdo;
   logic        wr_ff, nxt_wr, rdst_ff, nxt_rdst;
   logic [7:0]  a_ff, nxt_a, d_ff, nxt_d;
   logic        err_ff, nxt_err;

   assign bus.wr    = wr_ff;
   assign bus.rd    = rdst_ff;
   assign bus.addr  = a_ff;
   assign bus.wdata = d_ff;

   always_comb begin
      nxt_st = st_ff; nxt_base = base_ff; nxt_wd = wd_ff; nxt_rd = rd_ff;
      nxt_wr = 1'b0; nxt_rdst = 1'b0; nxt_a = a_ff; nxt_d = d_ff; nxt_err = err_ff;
      nxt_rdo = 16'h0000;
      if (sw_rd) begin
         case (sw_addr)
            fpb_pkg::HOST_ADDR_STAT: nxt_rdo = {13'h0000, err_ff, 1'b0, st_ff != S_IDLE};
            fpb_pkg::HOST_ADDR_RDAT: nxt_rdo = rd_ff;
            fpb_pkg::HOST_ADDR_WDAT: nxt_rdo = wd_ff;
            default:                 nxt_rdo = {8'h00, base_ff};
         endcase
      end
      case (st_ff)
         S_IDLE: begin
            if (sw_wr && sw_addr == fpb_pkg::HOST_ADDR_WDAT) begin
               nxt_wd = sw_wdata;
            end
            if (sw_wr && sw_addr == fpb_pkg::HOST_ADDR_CTRL) begin
               nxt_base = sw_wdata[7:0];
               // range of min period bound [RULE11]; ordering [RULE10] is left to software
               if (sw_wdata[8] && sw_wdata[7:0] == fpb_pkg::ADDR_MIN_LO && wd_ff < fpb_pkg::MIN_PERIOD_FLOOR) begin
                  nxt_err = 1'b1;
               end else begin
                  nxt_err = 1'b0;
                  nxt_st  = sw_wdata[8] ? S_WLO : S_RHI;
               end
            end
         end
         S_WLO: begin
            nxt_wr = 1'b1; nxt_a = base_ff; nxt_d = wd_ff[7:0]; nxt_st = S_WHI; // lower first [RULE4]
         end
         S_WHI: begin
            nxt_wr = 1'b1; nxt_a = base_ff + 8'h01; nxt_d = wd_ff[15:8]; nxt_st = S_IDLE;
            // busy must be polled by software before the next bound write [RULE8] [RULE9] [RULE13]
         end
         S_RHI: begin
            nxt_rdst = 1'b1; nxt_a = base_ff + 8'h01; nxt_st = S_RLO; // upper first [RULE3]
         end
         S_RLO: begin
            nxt_rdst = 1'b1; nxt_a = base_ff; nxt_st = S_RDONE;
         end
         S_RDONE: begin
            // rdata stands one cycle after each read strobe
            nxt_rd[15:8] = bus.rdata; nxt_st = S_RFIN;
         end
         S_RFIN: begin
            nxt_rd[7:0] = bus.rdata; nxt_st = S_IDLE;
         end
         default: nxt_st = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= S_IDLE; base_ff <= 8'h00; wd_ff <= 16'h0000; rd_ff <= 16'h0000;
         wr_ff <= 1'b0; rdst_ff <= 1'b0; a_ff <= 8'h00; d_ff <= 8'h00; err_ff <= 1'b0;
         rdo_ff <= 16'h0000;
      end else if (clk_en) begin
         st_ff <= nxt_st; base_ff <= nxt_base; wd_ff <= nxt_wd; rd_ff <= nxt_rd;
         wr_ff <= nxt_wr; rdst_ff <= nxt_rdst; a_ff <= nxt_a; d_ff <= nxt_d; err_ff <= nxt_err;
         rdo_ff <= nxt_rdo;
      end
   end
   assign sw_rdata = rdo_ff;
endmodule
`default_nettype wire

/* File: fpb_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fpb_sva (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   logic [7:0] sh_ff [8];
   logic [7:0] exp_ff;
   wire logic  lo = addr inside {8'h19, 8'h1b, 8'h1d};
   wire logic  hi = addr inside {8'h1a, 8'h1c, 8'h1e};
   // shadow of the last byte written to each bound register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sh_ff <= '{8'h00, fpb_pkg::RST_MAX_LO, fpb_pkg::RST_MAX_HI, fpb_pkg::RST_MIN_LO,
                    fpb_pkg::RST_MIN_HI, fpb_pkg::RST_EXP_LO, fpb_pkg::RST_EXP_HI, 8'h00};
         exp_ff <= 8'h00;
      end else begin
         if (wr && (lo || hi)) sh_ff[addr[2:0]] <= wdata;
         exp_ff <= sh_ff[addr[2:0]];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_write_lo_first: assert property (wr && lo |=> wr && addr == $past(addr) + 8'h01)
      else $error("upper byte write does not follow lower");
   a_hi_after_lo: assert property (wr && hi |-> $past(wr) && $past(addr) == addr - 8'h01)
      else $error("upper byte written without lower first");
   a_read_hi_first: assert property (rd && hi |=> rd && addr == $past(addr) - 8'h01)
      else $error("lower byte read does not follow upper");
   a_lo_after_hi: assert property (rd && lo |-> $past(rd) && $past(addr) == addr + 8'h01)
      else $error("lower byte read without upper first");
   a_min_floor: assert property (wr && addr == 8'h1c |-> {wdata, $past(wdata)} >= 16'h0d3e)
      else $error("minimum period written below floor");
   a_bound_readback: assert property (rd && (lo || hi) |=> rdata == exp_ff)
      else $error("bound read does not return last write");
   a_unmapped_zero: assert property (rd && !(lo || hi) && addr != 8'h20 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_single_strobe: assert property (!(wr && rd))
      else $error("both strobes at once");
   c_activate: cover property (wr && addr == 8'h1a);
   c_min_read: cover property (rd && addr == 8'h1c);
   c_ext_write: cover property (wr && addr == 8'h20);
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  sw_addr = 2'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic        sw_wr = 1'b0;
   logic        sw_rd = 1'b0;
   logic [15:0] req_period = 16'h0000;
   logic [15:0] sw_rdata, frame_period, exposure_limit, got;
   logic        frame_tick, busy, auto_mode;
   int          failures = 0;
   int          check_count = 0;
   logic [7:0]  rb [5] = '{8'h19, 8'h1b, 8'h1d, 8'h20, 8'h30};
   logic [15:0] rv [5] = '{16'h6590, 16'h0e7e, 16'h4e20, 16'h0001, 16'h0000};
   fpb_if bus ();
   always #4 ref_clk = ~ref_clk;
   fpb_dev fpb_dev_i (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .bus(bus), .req_period(req_period),
      .req_exposure(16'h1234), .frame_period(frame_period), .exposure_limit(exposure_limit),
      .frame_tick(frame_tick), .busy(busy), .auto_mode(auto_mode));
   fpb_host fpb_host_i (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .bus(bus), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   fpb_sva fpb_sva_i (.ref_clk(ref_clk), .rst(rst), .wr(bus.wr), .rd(bus.rd), .addr(bus.addr),
      .wdata(bus.wdata), .rdata(bus.rdata));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task automatic sw_op(input logic w, input logic [1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= w;
      sw_rd <= !w;
      @(posedge ref_clk);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      @(negedge ref_clk);
      got = sw_rdata;
   endtask
   task automatic wr_pair(input logic [7:0] b, input logic [15:0] d);
      sw_op(1'b1, fpb_pkg::HOST_ADDR_WDAT, d);
      sw_op(1'b1, fpb_pkg::HOST_ADDR_CTRL, {7'h00, 1'b1, b});
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic rd_pair(input logic [7:0] b);
      sw_op(1'b1, fpb_pkg::HOST_ADDR_CTRL, {7'h00, 1'b0, b});
      repeat (6) @(posedge ref_clk);
      sw_op(1'b0, fpb_pkg::HOST_ADDR_RDAT, 16'h0000);
   endtask
   // cycles from now up to the next frame end
   task automatic next_tick(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (frame_tick !== 1'b1);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge ref_clk);
      failures++;
      test_done;
   end
   initial begin
      int n;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk("frame_period", 16'h6590, frame_period);
      chk("busy", 16'h0000, {15'h0, busy});
      for (int i = 0; i < 5; i++) begin
         rd_pair(rb[i]);
         chk("reset read", rv[i], got);
      end
      $display("test reset values done");
      wr_pair(8'h1b, 16'h0d3d);
      sw_op(1'b0, fpb_pkg::HOST_ADDR_STAT, 16'h0000);
      chk("err", 16'h0001, {15'h0, got[2]});
      rd_pair(8'h1b);
      chk("min kept", 16'h0e7e, got);
      wr_pair(8'h1b, 16'h0d3e);
      rd_pair(8'h1b);
      chk("min pending", 16'h0d3e, got);
      wr_pair(8'h1d, 16'h0100);
      wr_pair(8'h20, 16'h0000);
      chk("auto_mode", 16'h0000, {15'h0, auto_mode});
      chk("exposure held", 16'h4e20, exposure_limit);
      wr_pair(8'h19, 16'h1000);
      chk("busy set", 16'h0001, {15'h0, busy});
      chk("exposure pending", 16'h4e20, exposure_limit);
      for (n = 0; n < 60000 && busy !== 1'b0; n++) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("busy clear", 16'h0000, {15'h0, busy});
      chk("exposure active", 16'h0100, exposure_limit);
      next_tick(n);
      next_tick(n);
      chk("frame spacing", 16'h1000, n[15:0]);
      chk("manual period", 16'h1000, frame_period);
      $display("test activation done");
      wr_pair(8'h20, 16'h0001);
      next_tick(n);
      next_tick(n);
      @(negedge ref_clk);
      chk("auto floor", 16'h0d3e, frame_period);
      $display("test auto floor done");
      test_done;
   end
endmodule
`default_nettype wire
